// *** plc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RL1) Watt loss: V-ratio^2*iron + I-ratio^2*copper, times VA
// (RL2) VAR loss: V-ratio^4*iron + I-ratio^2*copper, times VA
// (RL3) Host supplies four percentage coefficients
// (RL4) Losses added to or subtracted from readings
// (RL5) Selection applies to received, reversed for delivered
// (RL6) Each phase computed separately every reading
// (RL7) Correct one-second readings before downstream use
// (RL8) Downstream sees only compensated values
// (RL9) Same arithmetic serves line loss compensation
// (RL10) Separate iron and copper loss enables
// (RL11) Finish before next strobe; flag valid output
module plc_core
  import plc_pkg::*;
#(
  parameter int PH = PLC_PHASES
) (
  input  wire logic                    CLOCK_IN,
  input  wire logic                    NRST_IN,
  input  wire logic                    READING_STB_IN,     // One-second strobe
  input  wire logic [PH*PLC_MEAS_W-1:0] VOLTS_IN,
  input  wire logic [PH*PLC_MEAS_W-1:0] AMPS_IN,
  input  wire logic [PH*PLC_PWR_W-1:0]  WATTS_IN,
  input  wire logic [PH*PLC_PWR_W-1:0]  VARS_IN,
  input  wire logic [PLC_MEAS_W-1:0]   CAL_VOLTS_IN,
  input  wire logic [PLC_MEAS_W-1:0]   CAL_AMPS_IN,
  input  wire logic [PLC_VA_W-1:0]     FULL_SCALE_VA_IN,
  input  wire logic [PLC_PCT_W-1:0]    IRON_WATT_LOSS_PCT_IN,
  input  wire logic [PLC_PCT_W-1:0]    COPPER_WATT_LOSS_PCT_IN,
  input  wire logic [PLC_PCT_W-1:0]    IRON_VAR_LOSS_PCT_IN,
  input  wire logic [PLC_PCT_W-1:0]    COPPER_VAR_LOSS_PCT_IN,
  input  wire logic                    IRON_EN_IN,
  input  wire logic                    COPPER_EN_IN,
  input  wire logic                    SUBTRACT_IN,        // 0 add, 1 subtract
  input  wire logic                    RECEIVED_POS_IN,    // Received is +P
  output logic [PH*PLC_PWR_W-1:0]      COMP_WATTS_OUT,
  output logic [PH*PLC_PWR_W-1:0]      COMP_VARS_OUT,
  output logic                         COMP_VALID_OUT,     // One-cycle pulse
  output logic                         OVERRUN_OUT         // Strobe while busy
);
  typedef enum logic [2:0] {
    PLC_IDLE  = 3'h0,   // Waiting for strobe
    PLC_DIVV  = 3'h1,   // Voltage ratio
    PLC_DIVI  = 3'h2,   // Current ratio
    PLC_MATH  = 3'h3,   // Loss products and correction
    PLC_DONE  = 3'h4    // Publish results
  } plc_state_e;

  localparam int PW = $clog2(PH + 1);
  localparam int WW = 2 * PLC_RAT_W;           // Squared ratio width

  plc_state_e          st_reg, st_next;
  logic [PW-1:0]       ph_reg, ph_next;        // Phase being worked
  logic [PLC_RAT_W-1:0] vr_reg, vr_next;       // Voltage ratio Q8.16
  logic [PLC_RAT_W-1:0] ir_reg, ir_next;       // Current ratio Q8.16
  // Snapshot of inputs, so that a late upstream change cannot mix readings
  logic [PH*PLC_MEAS_W-1:0] v_reg, v_next, i_reg, i_next;
  logic [PH*PLC_PWR_W-1:0]  w_reg, w_next, q_reg, q_next;
  logic [PH*PLC_PWR_W-1:0]  cw_reg, cw_next, cq_reg, cq_next;
  // Published copies, moved over only once every phase is done, so that
  // downstream never sees a reading with some phases old and some new
  logic [PH*PLC_PWR_W-1:0]  ow_reg, ow_next, oq_reg, oq_next;
  logic                valid_reg, valid_next;
  logic                ovr_reg, ovr_next;
  logic                div_start;
  logic [PLC_MEAS_W-1:0] div_num, div_den;
  logic                div_done;
  logic [PLC_RAT_W-1:0] div_quo;

  // Loss arithmetic, fixed point, evaluated combinationally for one phase
  logic [WW-1:0]       v2, i2, v4;
  logic [63:0]         wl_pct, ql_pct;         // Loss fraction, Q.32
  logic [63:0]         wl, ql;                 // Loss in VA units
  logic signed [PLC_PWR_W-1:0] wl_s, ql_s, w_in, q_in;
  logic                w_recv, q_recv, w_add, q_add;

  plc_div #(.NW(PLC_MEAS_W), .QW(PLC_RAT_W)) u_div (
    .clk   (CLOCK_IN),
    .nrst  (NRST_IN),
    .start (div_start),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quo   (div_quo)
  );

  // Saturate a wide loss into the signed power range
  function automatic logic signed [PLC_PWR_W-1:0] sat(input logic [63:0] x);
    if (x[63:PLC_PWR_W-1] != '0)
      sat = {1'b0, {(PLC_PWR_W-1){1'b1}}};
    else
      sat = PLC_PWR_W'(x);
  endfunction

  // Loss terms for the current phase
  always_comb begin
    v2 = WW'(vr_reg) * WW'(vr_reg) >> PLC_RAT_FRAC;          // RL1
    i2 = WW'(ir_reg) * WW'(ir_reg) >> PLC_RAT_FRAC;          // RL1
    v4 = WW'(v2[PLC_RAT_W+7:0]) * WW'(v2[PLC_RAT_W+7:0])
         >> PLC_RAT_FRAC;                                    // RL2
    // Iron and copper terms gated separately
    wl_pct = (IRON_EN_IN ? 64'(v2) * 64'(IRON_WATT_LOSS_PCT_IN) : 64'h0)
           + (COPPER_EN_IN ? 64'(i2) * 64'(COPPER_WATT_LOSS_PCT_IN)
                           : 64'h0);                         // RL10
    ql_pct = (IRON_EN_IN ? 64'(v4) * 64'(IRON_VAR_LOSS_PCT_IN) : 64'h0)
           + (COPPER_EN_IN ? 64'(i2) * 64'(COPPER_VAR_LOSS_PCT_IN)
                           : 64'h0);                         // RL10
    // Scale by full-scale VA; drop ratio and coefficient fractions
    wl = ((wl_pct >> PLC_RAT_FRAC) * 64'(FULL_SCALE_VA_IN))
         >> PLC_PCT_FRAC;                                    // RL1 RL9
    ql = ((ql_pct >> PLC_RAT_FRAC) * 64'(FULL_SCALE_VA_IN))
         >> PLC_PCT_FRAC;                                    // RL2 RL9
    wl_s = sat(wl);
    ql_s = sat(ql);
    w_in = w_reg[ph_reg*PLC_PWR_W +: PLC_PWR_W];
    q_in = q_reg[ph_reg*PLC_PWR_W +: PLC_PWR_W];
    // Received flow by sign of watts; VARs follow the watt direction
    w_recv = RECEIVED_POS_IN ? !w_in[PLC_PWR_W-1] : w_in[PLC_PWR_W-1];
    q_recv = w_recv;
    // Add mode adds loss to received, subtracts it from delivered
    w_add  = (SUBTRACT_IN == PLC_ADD_MODE[0]) == w_recv;     // RL5
    q_add  = (SUBTRACT_IN == PLC_ADD_MODE[0]) == q_recv;     // RL5
  end

  // Sequencer: per phase two divides, then the correction
  always_comb begin
    st_next    = st_reg;
    ph_next    = ph_reg;
    vr_next    = vr_reg;
    ir_next    = ir_reg;
    v_next     = v_reg;
    i_next     = i_reg;
    w_next     = w_reg;
    q_next     = q_reg;
    cw_next    = cw_reg;
    cq_next    = cq_reg;
    ow_next    = ow_reg;
    oq_next    = oq_reg;
    valid_next = 1'b0;
    ovr_next   = ovr_reg;
    div_start  = 1'b0;
    div_num    = v_reg[ph_reg*PLC_MEAS_W +: PLC_MEAS_W];
    div_den    = CAL_VOLTS_IN;
    if (st_reg == PLC_DIVI) begin
      div_num = i_reg[ph_reg*PLC_MEAS_W +: PLC_MEAS_W];
      div_den = CAL_AMPS_IN;
    end
    // Strobe while busy is dropped and latched as overrun
    if (READING_STB_IN && st_reg != PLC_IDLE)
      ovr_next = 1'b1;                                       // RL11
    unique case (st_reg)
      PLC_IDLE: begin
        if (READING_STB_IN) begin
          v_next  = VOLTS_IN;
          i_next  = AMPS_IN;
          w_next  = WATTS_IN;
          q_next  = VARS_IN;
          ph_next = '0;
          ovr_next = 1'b0;
          st_next = PLC_DIVV;
          div_start = 1'b1;
          div_num = VOLTS_IN[PLC_MEAS_W-1:0];
        end
      end
      PLC_DIVV: begin
        if (div_done) begin
          vr_next   = div_quo;
          div_start = 1'b1;
          div_num   = i_reg[ph_reg*PLC_MEAS_W +: PLC_MEAS_W];
          div_den   = CAL_AMPS_IN;
          st_next   = PLC_DIVI;
        end
      end
      PLC_DIVI: begin
        if (div_done) begin
          ir_next = div_quo;
          st_next = PLC_MATH;
        end
      end
      PLC_MATH: begin
        // Apply this phase's own correction
        cw_next[ph_reg*PLC_PWR_W +: PLC_PWR_W] =
          w_add ? w_in + wl_s : w_in - wl_s;                 // RL4 RL6
        cq_next[ph_reg*PLC_PWR_W +: PLC_PWR_W] =
          q_add ? q_in + ql_s : q_in - ql_s;                 // RL4 RL6
        if (ph_reg == PW'(PH - 1)) begin
          st_next = PLC_DONE;
        end else begin
          ph_next   = ph_reg + 1'b1;
          div_start = 1'b1;
          div_num   = v_reg[(ph_reg+1)*PLC_MEAS_W +: PLC_MEAS_W];
          div_den   = CAL_VOLTS_IN;
          st_next   = PLC_DIVV;
        end
      end
      PLC_DONE: begin
        valid_next = 1'b1;                                   // RL11
        ow_next    = cw_reg;                                 // RL8
        oq_next    = cq_reg;                                 // RL8
        st_next    = PLC_IDLE;
      end
      default: st_next = PLC_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_reg    <= PLC_IDLE;
      ph_reg    <= '0;
      vr_reg    <= '0;
      ir_reg    <= '0;
      v_reg     <= '0;
      i_reg     <= '0;
      w_reg     <= '0;
      q_reg     <= '0;
      cw_reg    <= '0;
      cq_reg    <= '0;
      ow_reg    <= '0;
      oq_reg    <= '0;
      valid_reg <= 1'b0;
      ovr_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      ph_reg    <= ph_next;
      vr_reg    <= vr_next;
      ir_reg    <= ir_next;
      v_reg     <= v_next;
      i_reg     <= i_next;
      w_reg     <= w_next;
      q_reg     <= q_next;
      cw_reg    <= cw_next;
      cq_reg    <= cq_next;
      ow_reg    <= ow_next;
      oq_reg    <= oq_next;
      valid_reg <= valid_next;
      ovr_reg   <= ovr_next;
    end
  end

  // Only compensated values leave the block
  assign COMP_WATTS_OUT = ow_reg;                            // RL7 RL8
  assign COMP_VARS_OUT  = oq_reg;                            // RL7 RL8
  assign COMP_VALID_OUT = valid_reg;
  assign OVERRUN_OUT    = ovr_reg;
endmodule
`default_nettype wire

// *** plc_pkg.sv ***
package plc_pkg;
  // Datapath widths
  localparam int PLC_PHASES   = 3;   // Metering elements
  localparam int PLC_MEAS_W   = 16;  // Unsigned voltage / current magnitude
  localparam int PLC_PWR_W    = 32;  // Signed watt / VAR readings
  localparam int PLC_PCT_W    = 16;  // Coefficient width
  localparam int PLC_PCT_FRAC = 16;  // Coefficient fraction bits (Q0.16 of 1.0)
  localparam int PLC_VA_W     = 24;  // Full-scale secondary VA
  localparam int PLC_RAT_FRAC = 16;  // Ratio fraction bits
  localparam int PLC_RAT_W    = 24;  // Ratio width (Q8.16)
  // Unused; the sequencer takes three steps per phase (DIVV, DIVI, MATH)
  localparam int PLC_STEPS    = 4;
  localparam logic [1:0] PLC_ADD_MODE = 2'h0; // Select value meaning add
endpackage

// *** plc_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// Radix-2 restoring divider: quotient of num/den, fraction bits included
module plc_div
  import plc_pkg::*;
#(
  parameter int NW = PLC_MEAS_W,
  parameter int QW = PLC_RAT_W
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          start,     // One-cycle start pulse
  input  wire logic [NW-1:0] num,
  input  wire logic [NW-1:0] den,
  output logic               done,      // One-cycle completion pulse
  output logic [QW-1:0]      quo
);
  localparam int CW = $clog2(QW + 1);
  logic [QW-1:0] quo_reg, quo_next;     // Quotient being built
  logic [NW:0]   rem_reg, rem_next;     // Partial remainder
  logic [QW-1:0] dnd_reg, dnd_next;     // Dividend shift-out
  logic [NW-1:0] den_reg, den_next;
  logic [CW-1:0] cnt_reg, cnt_next;     // Bits left
  logic          done_reg, done_next;
  logic [NW:0]   trial;

  // One quotient bit per cycle; zero divisor saturates to all ones
  always_comb begin
    quo_next  = quo_reg;
    rem_next  = rem_reg;
    dnd_next  = dnd_reg;
    den_next  = den_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    trial     = {rem_reg[NW-1:0], dnd_reg[QW-1]};
    if (start) begin
      quo_next = '0;
      // Upper dividend bits seed the remainder; ratio must stay below 256
      rem_next = (NW+1)'(num >> (NW + PLC_RAT_FRAC - QW));
      dnd_next = QW'({num, {PLC_RAT_FRAC{1'b0}}});
      den_next = den;
      cnt_next = CW'(QW);
    end else if (cnt_reg != '0) begin
      dnd_next = {dnd_reg[QW-2:0], 1'b0};
      if (trial >= {1'b0, den_reg}) begin
        rem_next = trial - {1'b0, den_reg};
        quo_next = {quo_reg[QW-2:0], 1'b1};
      end else begin
        rem_next = trial;
        quo_next = {quo_reg[QW-2:0], 1'b0};
      end
      cnt_next = cnt_reg - 1'b1;
      done_next = (cnt_reg == CW'(1));
    end
  end

  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quo_reg  <= '0;
      rem_reg  <= '0;
      dnd_reg  <= '0;
      den_reg  <= '0;
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      quo_reg  <= quo_next;
      rem_reg  <= rem_next;
      dnd_reg  <= dnd_next;
      den_reg  <= den_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
  assign quo  = (den_reg == '0) ? '1 : quo_reg;
endmodule
`default_nettype wire

// *** plc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of strobe, valid, overrun and held results
module plc_monitor
  import plc_pkg::*;
#(
  parameter int PH = PLC_PHASES
) (
  input wire logic                   CLOCK_IN,
  input wire logic                   NRST_IN,
  input wire logic                   READING_STB_IN,
  input wire logic [PH*PLC_PWR_W-1:0] COMP_WATTS_OUT,
  input wire logic [PH*PLC_PWR_W-1:0] COMP_VARS_OUT,
  input wire logic                   COMP_VALID_OUT,
  input wire logic                   OVERRUN_OUT
);
  logic busy_reg;  // Accepted reading not yet answered
  logic busy_next;
  // Strobe and valid never share an edge under the spacing rule
  always_comb begin
    busy_next = busy_reg;
    if (COMP_VALID_OUT) busy_next = 1'b0;
    else if (READING_STB_IN) busy_next = 1'b1;
  end
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) busy_reg <= 1'b0;
    else busy_reg <= busy_next;
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);
  a_valid_single: assert property (COMP_VALID_OUT |=> !COMP_VALID_OUT)
    else $error("valid longer than one cycle");
  a_valid_bound: assert property (READING_STB_IN && !busy_reg |->
    ##[1:200] COMP_VALID_OUT) else $error("valid late");
  a_valid_early: assert property (READING_STB_IN && !busy_reg |=>
    (!COMP_VALID_OUT) [*8]) else $error("valid too soon");
  a_valid_cause: assert property (COMP_VALID_OUT |-> busy_reg)
    else $error("valid without reading");
  a_out_held: assert property (!COMP_VALID_OUT |->
    $stable(COMP_WATTS_OUT) && $stable(COMP_VARS_OUT))
    else $error("results moved without valid");
  a_ovr_set: assert property (READING_STB_IN && busy_reg &&
    !COMP_VALID_OUT |=> OVERRUN_OUT) else $error("overrun missed");
  a_ovr_clear: assert property (READING_STB_IN && !busy_reg
    |=> !OVERRUN_OUT) else $error("overrun not cleared");
  a_ovr_hold: assert property (OVERRUN_OUT && !READING_STB_IN
    |=> OVERRUN_OUT) else $error("overrun dropped");
  a_ovr_cause: assert property ($rose(OVERRUN_OUT) |->
    $past(READING_STB_IN) && $past(busy_reg)) else $error("stray overrun");
endmodule
bind plc_core plc_monitor #(.PH(PH)) u_plc_monitor (
  .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .READING_STB_IN(READING_STB_IN),
  .COMP_WATTS_OUT(COMP_WATTS_OUT), .COMP_VARS_OUT(COMP_VARS_OUT),
  .COMP_VALID_OUT(COMP_VALID_OUT), .OVERRUN_OUT(OVERRUN_OUT));
`default_nettype wire

// *** plc_meas_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Upstream measurement stage: presents one reading with a strobe
module plc_meas_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req_in,     // Publish the given reading
  input  wire logic [47:0] v_in,
  input  wire logic [47:0] a_in,
  input  wire logic [95:0] w_in,
  input  wire logic [95:0] r_in,
  output logic             stb_out,
  output logic [47:0]      volts_out,
  output logic [95:0]      watts_out,
  output logic [47:0]      amps_out,
  output logic [95:0]      vars_out
);
  // Readings move on right after the strobe, so no late sampling passes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stb_out   <= 1'b0;
      volts_out <= '0;
      amps_out  <= '0;
      watts_out <= '0;
      vars_out  <= '0;
    end else if (req_in) begin
      stb_out   <= 1'b1;
      volts_out <= v_in;
      amps_out  <= a_in;
      watts_out <= w_in;
      vars_out  <= r_in;
    end else begin
      stb_out   <= 1'b0;
      // Next second's values are already on the way
      volts_out <= ~volts_out;
      amps_out  <= ~amps_out;
      watts_out <= ~watts_out;
      vars_out  <= ~vars_out;
    end
  end
endmodule
`default_nettype wire

// *** plc_core_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
// Sequences of readings under every enable, sign and flow setting
module plc_core_bench;
  localparam logic [15:0] CALV = 16'h03E8;  // Calibration volts
  localparam logic [15:0] CALA = 16'h0100;  // Calibration amps
  localparam logic [23:0] VA   = 24'h000400;
  localparam int VR [3] = '{1, 1, 2};  // Volts ratio per phase
  localparam int IR [3] = '{1, 2, 0};  // Amps ratio, zero included
  localparam logic [31:0] WV [3] = '{32'h00001388, 32'hFFFFE4A8, 32'h00000BB8};
  localparam logic [31:0] QV [3] = '{32'h000003E8, 32'h000007D0, 32'hFFFFFA24};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req = 1'b0;
  logic iron_en = 1'b0;
  logic cu_en = 1'b0;
  logic sub = 1'b0;
  logic rpos = 1'b0;
  logic [15:0] iw = 16'h0800;  // Coefficients, exact in binary
  logic [15:0] cw = 16'h0400;
  logic [15:0] iv = 16'h1000;
  logic [15:0] cv = 16'h0100;
  wire logic [47:0] vpk, apk;  // Packed stimulus, one slice per phase
  wire logic [95:0] wpk, qpk;
  logic [47:0] v, a;
  logic [95:0] w, q, cw_out, cq_out;
  logic stb, valid, ovr;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  for (genvar p = 0; p < 3; p++) begin : g_pack
    assign vpk[16*p +: 16] = 16'(VR[p]) * CALV;
    assign apk[16*p +: 16] = 16'(IR[p]) * CALA;
    assign wpk[32*p +: 32] = WV[p];
    assign qpk[32*p +: 32] = QV[p];
  end
  plc_meas_model u_plc_meas_model (.clk(clk), .nrst(nrst), .req_in(req),
    .v_in(vpk), .a_in(apk), .w_in(wpk), .r_in(qpk), .stb_out(stb),
    .volts_out(v), .amps_out(a), .watts_out(w), .vars_out(q));
  plc_core u_plc_core (.CLOCK_IN(clk), .NRST_IN(nrst), .READING_STB_IN(stb),
    .VOLTS_IN(v), .AMPS_IN(a), .WATTS_IN(w), .VARS_IN(q),
    .CAL_VOLTS_IN(CALV), .CAL_AMPS_IN(CALA), .FULL_SCALE_VA_IN(VA),
    .IRON_WATT_LOSS_PCT_IN(iw), .COPPER_WATT_LOSS_PCT_IN(cw),
    .IRON_VAR_LOSS_PCT_IN(iv), .COPPER_VAR_LOSS_PCT_IN(cv),
    .IRON_EN_IN(iron_en), .COPPER_EN_IN(cu_en), .SUBTRACT_IN(sub),
    .RECEIVED_POS_IN(rpos), .COMP_WATTS_OUT(cw_out), .COMP_VARS_OUT(cq_out),
    .COMP_VALID_OUT(valid), .OVERRUN_OUT(ovr));
  // Expected corrected reading of one phase, watts or VARs
  function automatic logic [31:0] exp_val(int p, bit isq);
    longint t;
    t = 0;
    if (iron_en) t += isq ? longint'(VR[p]**4) * iv : longint'(VR[p]**2) * iw;
    if (cu_en) t += longint'(IR[p]**2) * (isq ? cv : cw);
    t = (t * VA) >> 16;
    // Received flow takes the selected sign, delivered the other
    if ((($signed(WV[p]) >= 0) == rpos) ^ sub) return (isq ? QV[p] : WV[p]) + 32'(t);
    return (isq ? QV[p] : WV[p]) - 32'(t);
  endfunction
  // One reading; dbl adds a refused strobe while busy
  task automatic reading(bit dbl);
    int n;
    n = 0;
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
    if (dbl) begin
      repeat (10) @(posedge clk);
      req <= 1'b1;
      @(posedge clk) req <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK("overrun", 1'b1, ovr)
    end
    while (valid !== 1'b1 && n < 205) begin
      @(negedge clk);
      n++;
    end
    `CHK("answered", 1'b1, n < 205)
    for (int p = 0; p < 3; p++) begin
      `CHK("watts", exp_val(p, 0), cw_out[32*p +: 32])
      `CHK("vars", exp_val(p, 1), cq_out[32*p +: 32])
    end
    if (!dbl) `CHK("overrun clear", 1'b0, ovr)
    repeat (60) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, well above twenty readings
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      @(posedge clk) {rpos, sub, cu_en, iron_en} <= 4'(m);
      reading(0);
    end
    // Line-loss style coefficients through the same arithmetic
    @(posedge clk) {iw, cw, iv, cv} <= {cw, iw, cv, iv};
    reading(1);
    reading(0);
    end_of_test();
  end
endmodule
`default_nettype wire
